// File: ext_bus_pkg.sv
`default_nettype none
package ext_bus_pkg;
    localparam int          PHASES_PER_CYCLE = 12;
    localparam logic [3:0]  PH_LAST          = 4'hb;
    localparam logic [3:0]  PH_ALE_END       = 4'h4;
    localparam logic [3:0]  PH_ADDR_END      = 4'h8;
    localparam logic [3:0]  PH_WDATA_START   = 4'h8;
    localparam logic [3:0]  PH_STROBE_END    = 4'ha;
    localparam logic [3:0]  PH_READ_SAMPLE   = 4'hb;
    localparam logic [3:0]  PH_RESET_SAMPLE  = 4'h9;

    localparam logic [7:0]  OFS_PORT_ZERO    = 8'h80;
    localparam logic [7:0]  OFS_DP_LOW       = 8'h82;
    localparam logic [7:0]  OFS_DP_HIGH      = 8'h83;
    localparam logic [7:0]  OFS_PORT_TWO     = 8'ha0;
    localparam logic [7:0]  OFS_PORT_THREE   = 8'hb0;

    localparam logic [7:0]  RST_PORT_LATCH   = 8'hff;
    localparam logic [7:0]  RST_DP           = 8'h00;
    localparam logic [7:0]  PORT_ZERO_FILL   = 8'hff;
    localparam logic [7:0]  UNMAPPED_READ    = 8'h00;
    localparam logic [15:0] RESET_VECTOR     = 16'h0000;

    typedef enum logic [1:0] {
        KIND_FETCH = 2'b00,
        KIND_READ  = 2'b01,
        KIND_WRITE = 2'b10
    } acc_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ADDR   = 2'b01,
        ST_STROBE = 2'b10
    } bus_state_t;
endpackage : ext_bus_pkg
`default_nettype wire

// File: mcu_external_memory_bus.sv
`timescale 1ns/100ps
`default_nettype none
module mcu_external_memory_bus
    import ext_bus_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        reset_pin_i,
    input  wire logic        internal_code_disable_n_i,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic [7:0]  sfr_wdata_i,
    input  wire logic        sfr_rd_i,
    output logic      [7:0]  sfr_rdata_o,
    input  wire logic        sfr_bit_wr_i,
    input  wire logic [7:0]  sfr_bit_addr_i,
    input  wire logic        sfr_bit_val_i,
    input  wire logic        acc_req_i,
    input  wire logic [1:0]  acc_kind_i,
    input  wire logic        acc_ptr_form_i,
    input  wire logic [16:0] fetch_addr_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  acc_wdata_i,
    output logic             acc_ready_o,
    output logic             acc_done_o,
    output logic      [7:0]  acc_rdata_o,
    output logic             fetch_external_o,
    output logic             core_reset_o,
    output logic      [15:0] start_addr_o,
    output logic             host_prog_mode_o,
    input  wire logic [7:0]  port0_in_i,
    output logic      [7:0]  port0_out_o,
    output logic             port0_oe_o,
    output logic      [7:0]  port2_out_o,
    output logic      [7:0]  port3_out_o,
    output logic             addr_latch_strobe_o,
    input  wire logic        program_fetch_strobe_n_in_i,
    output logic             program_fetch_strobe_n_out_o,
    output logic             program_fetch_strobe_n_oe_o
);

    ////////////////////////////////////////////////////////////////////////////
    // machine cycle timing and pin synchronisers
    logic [3:0]  phase_reg;
    logic        cycle_end;
    logic [2:0]  rst_sync_reg;
    logic [2:0]  strap_sync_reg;
    logic [2:0]  program_fetch_strobe_sync_reg;
    logic [7:0]  p0_sync1_reg;
    logic [7:0]  p0_sync2_reg;
    logic [7:0]  p0_sync3_reg;
    logic        rst_sample_reg;
    logic        rst_prev_sample_reg;
    logic        rst_done_reg;
    logic        code_disable_reg;
    logic        program_fetch_strobe_level_reg;
    logic        prog_mode_reg;
    logic        core_reset;
    assign cycle_end = (phase_reg == PH_LAST);
    always_ff @(posedge clk_i) begin
        if (reset_i || cycle_end) begin
            phase_reg <= 4'h0;
        end else begin
            phase_reg <= phase_reg + 4'h1;
        end
    end

    // the first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        rst_sync_reg   <= {rst_sync_reg[1:0], reset_pin_i};
        strap_sync_reg <= {strap_sync_reg[1:0], internal_code_disable_n_i};
        program_fetch_strobe_sync_reg  <= {program_fetch_strobe_sync_reg[1:0], program_fetch_strobe_n_in_i};
        p0_sync1_reg   <= port0_in_i;
        p0_sync2_reg   <= p0_sync1_reg;
        p0_sync3_reg   <= p0_sync2_reg;
    end

    // a level counts only when stages two and three agree
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rst_sample_reg      <= 1'b0;
            rst_prev_sample_reg <= 1'b0;
        end else if (phase_reg == PH_RESET_SAMPLE && rst_sync_reg[1] == rst_sync_reg[2]) begin
            rst_sample_reg      <= rst_sync_reg[2];
            rst_prev_sample_reg <= rst_sample_reg;
        end
    end

    // two consecutive high samples make a complete reset; shorter pulses still reset the core
    always_ff @(posedge clk_i) begin
        if (reset_i || !rst_sample_reg) begin
            rst_done_reg <= 1'b0;
        end else if (rst_prev_sample_reg) begin
            rst_done_reg <= 1'b1;
        end
    end

    assign core_reset = reset_i || rst_sample_reg;
    // strap captured while reset is applied, never in the reset branch itself
    always_ff @(posedge clk_i) begin
        if (core_reset && strap_sync_reg[1] == strap_sync_reg[2]) begin
            code_disable_reg <= !strap_sync_reg[2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            program_fetch_strobe_level_reg <= 1'b1;
        end else if (program_fetch_strobe_sync_reg[1] == program_fetch_strobe_sync_reg[2]) begin
            program_fetch_strobe_level_reg <= program_fetch_strobe_sync_reg[2];
        end
    end

    // a forced falling edge on the fetch strobe during a held reset selects host programming
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prog_mode_reg <= 1'b0;
        end else if (rst_done_reg && program_fetch_strobe_level_reg && program_fetch_strobe_sync_reg[1] == program_fetch_strobe_sync_reg[2]
                     && !program_fetch_strobe_sync_reg[2]) begin
            prog_mode_reg <= 1'b1;
        end
    end

    assign host_prog_mode_o = prog_mode_reg;
    // only bus and register state restarts; on-chip data memory is owned elsewhere and kept
    assign core_reset_o     = core_reset;
    assign start_addr_o     = RESET_VECTOR;
    assign fetch_external_o = code_disable_reg || fetch_addr_i[16];
    ////////////////////////////////////////////////////////////////////////////
    // special registers
    logic [7:0] port_zero_latch_reg;
    logic [7:0] port_two_latch_reg;
    logic [7:0] port_three_latch_reg;
    logic [7:0] dp_low_reg;
    logic [7:0] dp_high_reg;
    logic [7:0] rdata_reg;
    logic       acc_go;
    logic       bit_hit;
    logic [7:0] bit_byte;
    logic [7:0] bit_mask;
    // only byte addresses that are multiples of eight take bit writes
    assign bit_byte = {sfr_bit_addr_i[7:3], 3'b000};
    assign bit_hit  = sfr_bit_wr_i && sfr_bit_addr_i[7];
    assign bit_mask = 8'h01 << sfr_bit_addr_i[2:0];
    function automatic logic [7:0] bit_merge(input logic [7:0] cur, input logic [7:0] mask, input logic val);
        bit_merge = val ? (cur | mask) : (cur & ~mask);
    endfunction : bit_merge
    // an external access overrides a same-cycle software write
    always_ff @(posedge clk_i) begin
        if (core_reset) begin
            port_zero_latch_reg <= RST_PORT_LATCH;
        end else if (acc_go) begin
            port_zero_latch_reg <= PORT_ZERO_FILL;
        end else if (sfr_wr_i && sfr_addr_i == OFS_PORT_ZERO) begin
            port_zero_latch_reg <= sfr_wdata_i;
        end else if (bit_hit && bit_byte == OFS_PORT_ZERO) begin
            port_zero_latch_reg <= bit_merge(port_zero_latch_reg, bit_mask, sfr_bit_val_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (core_reset) begin
            port_two_latch_reg <= RST_PORT_LATCH;
        end else if (sfr_wr_i && sfr_addr_i == OFS_PORT_TWO) begin
            port_two_latch_reg <= sfr_wdata_i;
        end else if (bit_hit && bit_byte == OFS_PORT_TWO) begin
            port_two_latch_reg <= bit_merge(port_two_latch_reg, bit_mask, sfr_bit_val_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (core_reset) begin
            port_three_latch_reg <= RST_PORT_LATCH;
        end else if (sfr_wr_i && sfr_addr_i == OFS_PORT_THREE) begin
            port_three_latch_reg <= sfr_wdata_i;
        end else if (bit_hit && bit_byte == OFS_PORT_THREE) begin
            port_three_latch_reg <= bit_merge(port_three_latch_reg, bit_mask, sfr_bit_val_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (core_reset) begin
            dp_low_reg  <= RST_DP;
            dp_high_reg <= RST_DP;
        end else if (sfr_wr_i && sfr_addr_i == OFS_DP_LOW) begin
            dp_low_reg  <= sfr_wdata_i;
        end else if (sfr_wr_i && sfr_addr_i == OFS_DP_HIGH) begin
            dp_high_reg <= sfr_wdata_i;
        end
    end

    // unoccupied addresses read as zero and ignore writes
    always_ff @(posedge clk_i) begin
        if (core_reset) begin
            rdata_reg <= UNMAPPED_READ;
        end else if (sfr_rd_i) begin
            if (sfr_addr_i == OFS_PORT_ZERO) begin
                rdata_reg <= port_zero_latch_reg;
            end else if (sfr_addr_i == OFS_DP_LOW) begin
                rdata_reg <= dp_low_reg;
            end else if (sfr_addr_i == OFS_DP_HIGH) begin
                rdata_reg <= dp_high_reg;
            end else if (sfr_addr_i == OFS_PORT_TWO) begin
                rdata_reg <= port_two_latch_reg;
            end else if (sfr_addr_i == OFS_PORT_THREE) begin
                rdata_reg <= port_three_latch_reg;
            end else begin
                rdata_reg <= UNMAPPED_READ;
            end
        end
    end

    assign sfr_rdata_o = rdata_reg;
    ////////////////////////////////////////////////////////////////////////////
    // external bus sequencer
    bus_state_t  state_reg;
    logic [1:0]  kind_reg;
    logic        wide_reg;
    logic [15:0] addr_reg;
    logic [7:0]  wdata_reg;
    logic [7:0]  acc_rdata_reg;
    logic        done_reg;
    logic        req_ok;
    logic        slot_free;
    logic [15:0] req_addr;
    logic        req_wide;
    // internal fetches never reach the pins, so they are not taken here
    assign req_ok    = acc_req_i && !core_reset && !prog_mode_reg
                       && (acc_kind_i != KIND_FETCH || fetch_external_o);
    assign slot_free = (state_reg == ST_IDLE) || (state_reg == ST_STROBE);
    assign acc_ready_o = slot_free && cycle_end && !core_reset && !prog_mode_reg;
    assign acc_go    = req_ok && slot_free && cycle_end;

    always_comb begin
        req_addr = fetch_addr_i[15:0];
        req_wide = 1'b1;
        if (acc_kind_i != KIND_FETCH) begin
            if (acc_ptr_form_i) begin
                req_addr = {dp_high_reg, dp_low_reg};
            end else begin
                req_addr = {8'h00, reg_addr_i};
                req_wide = 1'b0;
            end
        end
    end

    // chaining straight from the strobe cycle keeps port two on the bus with no restore gap
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (acc_go) begin
                        state_reg <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    if (cycle_end) begin
                        state_reg <= rst_sample_reg ? ST_IDLE : ST_STROBE;
                    end
                end
                ST_STROBE: begin
                    if (cycle_end) begin
                        state_reg <= acc_go ? ST_ADDR : ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            kind_reg  <= KIND_FETCH;
            wide_reg  <= 1'b0;
            addr_reg  <= 16'h0000;
            wdata_reg <= 8'h00;
        end else if (acc_go) begin
            kind_reg  <= acc_kind_i;
            wide_reg  <= req_wide;
            addr_reg  <= req_addr;
            wdata_reg <= acc_wdata_i;
        end
    end

    // the synchronised sample at the last phase reflects the pins before the strobe rises
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            acc_rdata_reg <= 8'h00;
            done_reg      <= 1'b0;
        end else begin
            done_reg <= (state_reg == ST_STROBE) && cycle_end;
            if (state_reg == ST_STROBE && phase_reg == PH_READ_SAMPLE && kind_reg != KIND_WRITE) begin
                acc_rdata_reg <= p0_sync3_reg;
            end
        end
    end

    assign acc_done_o  = done_reg;
    assign acc_rdata_o = acc_rdata_reg;
    ////////////////////////////////////////////////////////////////////////////
    // pin drive
    logic addr_phase;
    logic write_phase;
    logic strobe_on;
    assign addr_phase  = (state_reg == ST_ADDR) && (phase_reg < PH_ADDR_END);
    assign write_phase = (kind_reg == KIND_WRITE)
                         && (((state_reg == ST_ADDR) && (phase_reg >= PH_WDATA_START))
                             || (state_reg == ST_STROBE));
    assign strobe_on   = (state_reg == ST_STROBE) && (phase_reg < PH_STROBE_END);

    assign addr_latch_strobe_o = (state_reg == ST_ADDR) && (phase_reg < PH_ALE_END);
    // port zero is driven only for the low address and for write data; it floats at all other times, idle included
    assign port0_oe_o  = addr_phase || write_phase;
    assign port0_out_o = addr_phase ? addr_reg[7:0] : (write_phase ? wdata_reg : port_zero_latch_reg);
    assign port2_out_o = (state_reg != ST_IDLE && wide_reg) ? addr_reg[15:8] : port_two_latch_reg;
    // alternate functions pull the latch bits low only while active
    assign port3_out_o = port_three_latch_reg
                         & {!(strobe_on && kind_reg == KIND_READ),
                            !(strobe_on && kind_reg == KIND_WRITE), 6'h3f};
    // fetch strobe is released during reset so a host can force it
    assign program_fetch_strobe_n_oe_o  = !core_reset;
    assign program_fetch_strobe_n_out_o = !(strobe_on && kind_reg == KIND_FETCH);
    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_ale_addr_valid: assert property (@(posedge clk_i) disable iff (reset_i)
        $fell(addr_latch_strobe_o) |-> port0_oe_o && port0_out_o == addr_reg[7:0])
        else $error("low address not valid when latch strobe falls");
    a_write_data_window: assert property (@(posedge clk_i) disable iff (reset_i)
        $fell(port3_out_o[6]) && port_three_latch_reg[6] |-> $past(port0_oe_o, 2)
        && $past(port0_out_o, 2) == wdata_reg ##1 (!port3_out_o[6])[*8] ##2 port0_oe_o)
        else $error("write data does not frame the write strobe");
    a_wide_high_byte: assert property (@(posedge clk_i) disable iff (reset_i)
        state_reg != ST_IDLE && wide_reg |-> port2_out_o == addr_reg[15:8])
        else $error("high address byte missing on port two");
    a_narrow_port_two: assert property (@(posedge clk_i) disable iff (reset_i)
        state_reg != ST_IDLE && !wide_reg |-> port2_out_o == port_two_latch_reg)
        else $error("narrow access disturbed port two");
    a_port_two_restore: assert property (@(posedge clk_i) disable iff (reset_i)
        state_reg == ST_STROBE && cycle_end && !acc_go |=> port2_out_o == port_two_latch_reg)
        else $error("port two latch not restored");
    a_no_prog_write: assert property (@(posedge clk_i) disable iff (reset_i)
        kind_reg == KIND_FETCH |-> port3_out_o[6] == port_three_latch_reg[6])
        else $error("write strobe during program fetch");
    a_read_release: assert property (@(posedge clk_i) disable iff (reset_i)
        state_reg == ST_STROBE && kind_reg != KIND_WRITE |-> !port0_oe_o)
        else $error("port zero driven during read data phase");
    a_zero_latch_fill: assert property (@(posedge clk_i) disable iff (reset_i)
        acc_go && !core_reset |=> port_zero_latch_reg == PORT_ZERO_FILL)
        else $error("port zero latch not filled on access");
    a_reset_sample: assert property (@(posedge clk_i) disable iff (reset_i)
        $past(phase_reg) != PH_RESET_SAMPLE |-> $stable(rst_sample_reg))
        else $error("reset pin sampled outside its slot");
    a_write_abort: assert property (@(posedge clk_i) disable iff (reset_i)
        state_reg == ST_ADDR && cycle_end && rst_sample_reg |=> state_reg == ST_IDLE
        ##0 (port3_out_o[6] == port_three_latch_reg[6])[*8])
        else $error("write not suppressed by early reset");
    // the strobe stands for phases zero to nine of the strobe cycle, ten in all
    a_strobe_length: assert property (@(posedge clk_i) disable iff (reset_i)
        state_reg == ST_ADDR && cycle_end && !rst_sample_reg |=> strobe_on [*8] ##1 strobe_on [*2] ##1 !strobe_on)
        else $error("strobe length wrong");
endmodule : mcu_external_memory_bus
`default_nettype wire

// File: ext_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model (
    input  wire logic [7:0] p0_pin_i,
    input  wire logic [7:0] p2_pin_i,
    input  wire logic       ale_i,
    input  wire logic       rd_n_i,
    input  wire logic       wr_n_i,
    input  wire logic       program_fetch_strobe_n_i,
    output logic      [7:0] data_o,
    output logic      [15:0] fetch_addr_o
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  lo_latch;
    logic [7:0]  last;
    logic        active;
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
        lo_latch = 8'h00;
        last = 8'h00;
        fetch_addr_o = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////
    always @(negedge ale_i) lo_latch = p0_pin_i;
    always @(negedge program_fetch_strobe_n_i) fetch_addr_o = {p2_pin_i, lo_latch};
    // write lands when the strobe ends, so data must still stand on the bus
    always @(posedge wr_n_i) mem[{p2_pin_i, lo_latch}] = p0_pin_i;
    assign active = ~rd_n_i | ~program_fetch_strobe_n_i;
    always @* if (active) last = mem[{p2_pin_i, lo_latch}];
    // released bus shows the inverse, never a stale value that looks valid
    assign data_o = active ? mem[{p2_pin_i, lo_latch}] : ~last;
endmodule : ext_mem_model
`default_nettype wire

// File: mcu_external_memory_bus_test.sv
`timescale 1ns/100ps
`default_nettype none
module mcu_external_memory_bus_test;
    import ext_bus_pkg::*;
    logic clk_i = 0, reset_i = 1, reset_pin_i = 0, strap_n = 0;
    logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_bit_addr_i = 8'h00;
    logic sfr_wr_i = 0, sfr_rd_i = 0, sfr_bit_wr_i = 0, sfr_bit_val_i = 0;
    logic acc_req_i = 0, acc_ptr_form_i = 0, program_fetch_strobe_force = 1, done;
    logic [1:0] acc_kind_i = 2'b00;
    logic [16:0] fetch_addr_i = 17'h00000;
    logic [7:0] reg_addr_i = 8'h00, acc_wdata_i = 8'h00, sfr_rdata_o, acc_rdata_o, port0_out_o, port2_out_o;
    logic [7:0] port3_out_o, mem_data, p0_pin;
    logic [15:0] start_addr_o, seen_fetch;
    logic acc_ready_o, acc_done_o, fetch_external_o, core_reset_o, host_prog_mode_o, port0_oe_o;
    logic addr_latch_strobe_o, program_fetch_strobe_out, program_fetch_strobe_oe, program_fetch_strobe_pin;
    int error_cnt = 0, comparisons = 0, cycles = 0;
    assign p0_pin = port0_oe_o ? port0_out_o : mem_data;
    assign program_fetch_strobe_pin = program_fetch_strobe_oe ? program_fetch_strobe_out : program_fetch_strobe_force;
    mcu_external_memory_bus u_mcu_external_memory_bus (.clk_i(clk_i), .reset_i(reset_i),
        .reset_pin_i(reset_pin_i), .internal_code_disable_n_i(strap_n), .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
        .sfr_bit_wr_i(sfr_bit_wr_i), .sfr_bit_addr_i(sfr_bit_addr_i), .sfr_bit_val_i(sfr_bit_val_i),
        .acc_req_i(acc_req_i), .acc_kind_i(acc_kind_i), .acc_ptr_form_i(acc_ptr_form_i),
        .fetch_addr_i(fetch_addr_i), .reg_addr_i(reg_addr_i), .acc_wdata_i(acc_wdata_i),
        .acc_ready_o(acc_ready_o), .acc_done_o(acc_done_o), .acc_rdata_o(acc_rdata_o),
        .fetch_external_o(fetch_external_o), .core_reset_o(core_reset_o), .start_addr_o(start_addr_o),
        .host_prog_mode_o(host_prog_mode_o), .port0_in_i(p0_pin), .port0_out_o(port0_out_o),
        .port0_oe_o(port0_oe_o), .port2_out_o(port2_out_o), .port3_out_o(port3_out_o),
        .addr_latch_strobe_o(addr_latch_strobe_o), .program_fetch_strobe_n_in_i(program_fetch_strobe_pin),
        .program_fetch_strobe_n_out_o(program_fetch_strobe_out), .program_fetch_strobe_n_oe_o(program_fetch_strobe_oe));
    ext_mem_model u_ext_mem_model (.p0_pin_i(p0_pin), .p2_pin_i(port2_out_o), .ale_i(addr_latch_strobe_o),
        .rd_n_i(port3_out_o[7]), .wr_n_i(port3_out_o[6]), .program_fetch_strobe_n_i(program_fetch_strobe_pin), .data_o(mem_data),
        .fetch_addr_o(seen_fetch));
    ////////////////////////////////////////////////////////////////////////
    initial forever #20 clk_i = ~clk_i;
    task report_and_stop;
        if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1;
        @(negedge clk_i);
        sfr_wr_i = 0;
    endtask : sfr_write
    task sfr_read(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_i);
        sfr_addr_i = a;
        sfr_rd_i = 1;
        @(negedge clk_i);
        sfr_rd_i = 0;
        check({8'h00, sfr_rdata_o}, {8'h00, exp});
    endtask : sfr_read
    // rst_at: cycles after the take at which the reset pin rises, 0 for none
    task ext_acc(input logic [1:0] k, input logic ptr, input logic [15:0] a, input logic [7:0] wd,
                 input int rst_at, output logic got);
        int n;
        n = 0;
        got = 0;
        @(negedge clk_i);
        while (acc_ready_o !== 1'b1 && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        acc_req_i = 1;
        acc_kind_i = k;
        acc_ptr_form_i = ptr;
        fetch_addr_i = {1'b0, a};
        reg_addr_i = a[7:0];
        acc_wdata_i = wd;
        @(negedge clk_i);
        acc_req_i = 0;
        for (n = 1; n < 40 && !got; n++) begin
            if (n == rst_at) reset_pin_i = 1;
            @(negedge clk_i);
            if (acc_done_o === 1'b1) got = 1;
        end
    endtask : ext_acc
    task pin_reset_release;
        int n;
        repeat (30) @(negedge clk_i);
        reset_pin_i = 0;
        for (n = 0; n < 60 && core_reset_o !== 1'b0; n++) @(negedge clk_i);
    endtask : pin_reset_release
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge clk_i);
        reset_i = 0;
        // loaded after the model has cleared its array at time zero
        u_ext_mem_model.mem[16'h0abc] = 8'h96;
        check(start_addr_o, RESET_VECTOR);
        check({15'h0, fetch_external_o}, 16'h0001);
        sfr_read(OFS_PORT_TWO, RST_PORT_LATCH);
        sfr_read(OFS_DP_LOW, RST_DP);
        sfr_read(8'h81, UNMAPPED_READ);
        sfr_write(OFS_DP_LOW, 8'h34);
        sfr_write(OFS_DP_HIGH, 8'h12);
        sfr_write(OFS_PORT_TWO, 8'h5a);
        sfr_write(OFS_PORT_ZERO, 8'h33);
        ext_acc(KIND_WRITE, 1'b1, 16'h0000, 8'ha5, 0, done);
        check(u_ext_mem_model.mem[16'h1234], 16'h00a5);
        repeat (3) @(negedge clk_i);
        check(port2_out_o, 16'h005a);
        sfr_read(OFS_PORT_ZERO, PORT_ZERO_FILL);
        ext_acc(KIND_READ, 1'b1, 16'h0000, 8'h00, 0, done);
        check(acc_rdata_o, 16'h00a5);
        ext_acc(KIND_WRITE, 1'b0, 16'h0077, 8'h3c, 0, done);
        check(u_ext_mem_model.mem[16'h5a77], 16'h003c);
        ext_acc(KIND_READ, 1'b0, 16'h0077, 8'h00, 0, done);
        check(acc_rdata_o, 16'h003c);
        ext_acc(KIND_FETCH, 1'b0, 16'h0abc, 8'h00, 0, done);
        check({15'h0, done}, 16'h0001);
        check(seen_fetch, 16'h0abc);
        check(acc_rdata_o, 16'h0096);
        sfr_write(OFS_PORT_TWO, 8'h00);
        @(negedge clk_i);
        sfr_bit_addr_i = 8'ha3;
        sfr_bit_val_i = 1;
        sfr_bit_wr_i = 1;
        @(negedge clk_i);
        sfr_bit_wr_i = 0;
        sfr_read(OFS_PORT_TWO, 8'h08);
        // reset in the address cycle must drop the write
        ext_acc(KIND_WRITE, 1'b0, 16'h0011, 8'h77, 2, done);
        check({15'h0, done}, 16'h0000);
        pin_reset_release();
        check(u_ext_mem_model.mem[16'h0811], 16'h0000);
        sfr_read(OFS_PORT_TWO, RST_PORT_LATCH);
        ext_acc(KIND_WRITE, 1'b0, 16'h0022, 8'h66, 14, done);
        check({15'h0, done}, 16'h0001);
        check(u_ext_mem_model.mem[16'hff22], 16'h0066);
        pin_reset_release();
        reset_pin_i = 1;
        repeat (40) @(negedge clk_i);
        program_fetch_strobe_force = 0;
        repeat (12) @(negedge clk_i);
        check({15'h0, host_prog_mode_o}, 16'h0001);
        program_fetch_strobe_force = 1;
        pin_reset_release();
        ext_acc(KIND_FETCH, 1'b0, 16'h0abc, 8'h00, 0, done);
        check({15'h0, done}, 16'h0000);
        // strap now selects on-chip code; it is captured only while reset is held
        strap_n = 1;
        @(negedge clk_i);
        reset_i = 1;
        repeat (4) @(negedge clk_i);
        reset_i = 0;
        check({15'h0, host_prog_mode_o}, 16'h0000);
        check({15'h0, fetch_external_o}, 16'h0000);
        ext_acc(KIND_FETCH, 1'b0, 16'h0000, 8'h00, 0, done);
        check({15'h0, done}, 16'h0000);
        fetch_addr_i = 17'h10000;
        @(negedge clk_i);
        check({15'h0, fetch_external_o}, 16'h0001);
        report_and_stop();
    end
endmodule : mcu_external_memory_bus_test
`default_nettype wire
